// ==== strap_cfg.sv ====
/*
  strap capture and mii pin direction control for port five and the
  switch mii, with an apb register window.
  assumes pclk at 100 MHz runs during reset and the pins are async.
*/
`timescale 1ns/1ns
`include "strap_cfg_defs.svh"
module strap_cfg (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // mode strap for the switch mii, high selects mac mode
  input wire logic sw_mac_mode,
  // port five mii, phy side
  output logic p5_rx_clock,
  input wire logic p5_rx_valid_i,
  output logic p5_rx_valid_o,
  output logic p5_rx_valid_oe_n,
  input wire logic p5_rx_bit3_strap_fc_i,
  output logic p5_rx_bit3_strap_fc_o,
  output logic p5_rx_bit3_strap_fc_oe_n,
  input wire logic p5_rx_bit2_strap_bp_i,
  output logic p5_rx_bit2_strap_bp_o,
  output logic p5_rx_bit2_strap_bp_oe_n,
  input wire logic p5_rx_bit1_strap_coldrop_i,
  output logic p5_rx_bit1_strap_coldrop_o,
  output logic p5_rx_bit1_strap_coldrop_oe_n,
  input wire logic p5_rx_bit0_strap_backoff_i,
  output logic p5_rx_bit0_strap_backoff_o,
  output logic p5_rx_bit0_strap_backoff_oe_n,
  input wire logic p5_rx_error_strap_size_i,
  output logic p5_rx_error_strap_size_o,
  output logic p5_rx_error_strap_size_oe_n,
  input wire logic p5_carrier_strap_duplex_i,
  output logic p5_carrier_strap_duplex_o,
  output logic p5_carrier_strap_duplex_oe_n,
  input wire logic p5_collision_strap_forcefc_i,
  output logic p5_collision_strap_forcefc_o,
  output logic p5_collision_strap_forcefc_oe_n,
  // switch mii pins
  input wire logic sw_tx_clock_i,
  output logic sw_tx_clock_o,
  output logic sw_tx_clock_oe_n,
  input wire logic sw_rx_clock_i,
  output logic sw_rx_clock_o,
  output logic sw_rx_clock_oe_n,
  input wire logic sw_tx_enable,
  input wire logic sw_tx_bit3,
  input wire logic sw_tx_bit2,
  input wire logic sw_tx_bit1,
  input wire logic sw_tx_bit0,
  input wire logic sw_tx_error,
  input wire logic sw_rx_valid_i,
  output logic sw_rx_valid_o,
  output logic sw_rx_valid_oe_n,
  input wire logic sw_rx_bit3_strap_fc_i,
  output logic sw_rx_bit3_strap_fc_o,
  output logic sw_rx_bit3_strap_fc_oe_n,
  input wire logic sw_rx_bit2_strap_duplex_i,
  output logic sw_rx_bit2_strap_duplex_o,
  output logic sw_rx_bit2_strap_duplex_oe_n,
  // user side receive data toward the pins
  input wire logic p5_rx_valid_in,
  input wire logic [3:0] p5_rx_data_in,
  input wire logic p5_rx_err_in,
  input wire logic p5_crs_in,
  input wire logic p5_col_in,
  input wire logic sw_rx_valid_in,
  input wire logic [1:0] sw_rx_data_in,
  // user side transmit nibbles from the switch mii
  output logic sw_tx_stb,
  output logic sw_tx_en_q,
  output logic [3:0] sw_tx_nib_q,
  output logic sw_tx_err_q,
  // captured settings
  output logic [`CFG_W-1:0] cfg_q,
  output logic cfg_done
);
  strap_cfg_pkg::cfg_state_e state_q;
  strap_cfg_pkg::mii_mode_e mode_q;
  logic [1:0] ctrl_q;
  logic [15:0] txcnt_q;
  logic [7:0] div_q;
  logic mii_clk_q;
  logic div_rise;
  logic div_fall;
  logic tx_edge;
  logic sw_rx_fall;
  logic pins_oe_n;
  logic clk_oe_n;
  logic [7:0] p5_out_q;
  logic [2:0] sw_out_q;
  logic [`STRAP_W-1:0] strap_now;
  logic [`LINK_W-1:0] link_now;
  logic bus_ok;
  logic [31:0] rd_word;
  localparam int clk_half_cyc = `MII_CLK_HALF_CYC;

  sync_if #(.W(`STRAP_W)) strap_s ();
  sync_if #(.W(`LINK_W)) link_s ();

  assign strap_s.raw = {sw_mac_mode, sw_rx_bit2_strap_duplex_i, sw_rx_bit3_strap_fc_i,
                        p5_collision_strap_forcefc_i, p5_carrier_strap_duplex_i,
                        p5_rx_error_strap_size_i, p5_rx_bit0_strap_backoff_i,
                        p5_rx_bit1_strap_coldrop_i, p5_rx_bit2_strap_bp_i,
                        p5_rx_bit3_strap_fc_i};
  assign link_s.raw = {sw_tx_error, sw_tx_bit3, sw_tx_bit2, sw_tx_bit1, sw_tx_bit0,
                       sw_tx_enable, sw_rx_clock_i, sw_tx_clock_i};

  pin_sync #(.W(`STRAP_W)) u_strap_sync (.pclk(pclk), .s(strap_s));
  pin_sync #(.W(`LINK_W)) u_link_sync (.pclk(pclk), .s(link_s));

  assign strap_now = strap_s.level;
  assign link_now = link_s.level;

  // one sample at the first edge after release, then frozen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= strap_cfg_pkg::cfg_sample;
    end else begin
      case (state_q)
        strap_cfg_pkg::cfg_sample: state_q <= strap_cfg_pkg::cfg_run; // [R15]
        strap_cfg_pkg::cfg_run: state_q <= strap_cfg_pkg::cfg_run;
        default: state_q <= strap_cfg_pkg::cfg_sample;
      endcase
    end
  end
  assign cfg_done = (state_q == strap_cfg_pkg::cfg_run);

  // reset values are the pull-down defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `CFG_RESET;
      mode_q <= strap_cfg_pkg::mode_phy;
    end else if (state_q == strap_cfg_pkg::cfg_sample) begin // [R15]
      cfg_q[`STRAP_P5_FC] <= ~strap_now[`STRAP_P5_FC]; // [R01]
      cfg_q[`STRAP_P5_BP] <= strap_now[`STRAP_P5_BP]; // [R02]
      cfg_q[`STRAP_P5_COLDROP] <= ~strap_now[`STRAP_P5_COLDROP]; // [R03]
      cfg_q[`STRAP_P5_BACKOFF] <= strap_now[`STRAP_P5_BACKOFF]; // [R04]
      cfg_q[`STRAP_P5_SIZE] <= strap_now[`STRAP_P5_SIZE]; // [R05]
      cfg_q[`STRAP_P5_DUPLEX] <= strap_now[`STRAP_P5_DUPLEX]; // [R06]
      cfg_q[`STRAP_P5_FORCEFC] <= strap_now[`STRAP_P5_FORCEFC]; // [R07]
      cfg_q[`STRAP_SW_FC] <= strap_now[`STRAP_SW_FC]; // [R08]
      cfg_q[`STRAP_SW_DUPLEX] <= strap_now[`STRAP_SW_DUPLEX]; // [R09]
      mode_q <= strap_now[`STRAP_MAC_MODE] ? strap_cfg_pkg::mode_mac
                                          : strap_cfg_pkg::mode_phy;
    end
  end

  // mii clock divider, runs from reset so port five always has a clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 8'h00;
      mii_clk_q <= 1'b0;
    end else if (div_q == 8'(`MII_CLK_HALF_CYC - 1)) begin
      div_q <= 8'h00;
      mii_clk_q <= ~mii_clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign div_rise = (div_q == 8'(`MII_CLK_HALF_CYC - 1)) && !mii_clk_q;
  assign div_fall = (div_q == 8'(`MII_CLK_HALF_CYC - 1)) && mii_clk_q;
  assign p5_rx_clock = mii_clk_q; // [R12]

  // switch clocks stay inputs until the mode is latched, to avoid a fight
  assign clk_oe_n = !(cfg_done && mode_q == strap_cfg_pkg::mode_phy); // [R16] [R10] [R11]
  assign sw_tx_clock_o = mii_clk_q; // [R10]
  assign sw_rx_clock_o = mii_clk_q; // [R11]
  assign sw_tx_clock_oe_n = clk_oe_n;
  assign sw_rx_clock_oe_n = clk_oe_n;

  // strap pins become outputs after capture unless software holds them off
  assign pins_oe_n = !(cfg_done && ctrl_q[`CTRL_DRIVE_BIT]); // [R14]
  assign p5_rx_valid_oe_n = pins_oe_n;
  assign p5_rx_bit3_strap_fc_oe_n = pins_oe_n;
  assign p5_rx_bit2_strap_bp_oe_n = pins_oe_n;
  assign p5_rx_bit1_strap_coldrop_oe_n = pins_oe_n;
  assign p5_rx_bit0_strap_backoff_oe_n = pins_oe_n;
  assign p5_rx_error_strap_size_oe_n = pins_oe_n;
  assign p5_carrier_strap_duplex_oe_n = pins_oe_n;
  assign p5_collision_strap_forcefc_oe_n = pins_oe_n;
  assign sw_rx_valid_oe_n = pins_oe_n;
  assign sw_rx_bit3_strap_fc_oe_n = pins_oe_n;
  assign sw_rx_bit2_strap_duplex_oe_n = pins_oe_n;

  // receive data change on the falling clock so they are stable at the rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p5_out_q <= 8'h00;
    end else if (div_fall) begin
      p5_out_q <= {p5_col_in, p5_crs_in, p5_rx_err_in, p5_rx_data_in, p5_rx_valid_in}; // [R14]
    end
  end
  assign sw_rx_fall = (mode_q == strap_cfg_pkg::mode_mac) ? link_s.fall[`LINK_RX_CLK] : div_fall;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_out_q <= 3'h0;
    end else if (sw_rx_fall) begin
      sw_out_q <= {sw_rx_data_in, sw_rx_valid_in}; // [R14]
    end
  end
  assign p5_rx_valid_o = p5_out_q[0];
  assign p5_rx_bit0_strap_backoff_o = p5_out_q[1];
  assign p5_rx_bit1_strap_coldrop_o = p5_out_q[2];
  assign p5_rx_bit2_strap_bp_o = p5_out_q[3];
  assign p5_rx_bit3_strap_fc_o = p5_out_q[4];
  assign p5_rx_error_strap_size_o = p5_out_q[5];
  assign p5_carrier_strap_duplex_o = p5_out_q[6];
  assign p5_collision_strap_forcefc_o = p5_out_q[7];
  assign sw_rx_valid_o = sw_out_q[0];
  assign sw_rx_bit2_strap_duplex_o = sw_out_q[1];
  assign sw_rx_bit3_strap_fc_o = sw_out_q[2];

  // transmit nibbles sampled on the tx clock rise, ours or the partner's
  assign tx_edge = cfg_done && ctrl_q[`CTRL_CAPTURE_BIT] &&
                   ((mode_q == strap_cfg_pkg::mode_mac) ? link_s.rise[`LINK_TX_CLK] : div_rise);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_tx_stb <= 1'b0;
      sw_tx_en_q <= 1'b0;
      sw_tx_nib_q <= 4'h0;
      sw_tx_err_q <= 1'b0;
    end else begin
      sw_tx_stb <= tx_edge;
      if (tx_edge) begin
        sw_tx_en_q <= link_now[`LINK_TX_EN]; // [R13]
        sw_tx_nib_q <= link_now[`LINK_TX_D0 +: 4]; // [R13]
        sw_tx_err_q <= link_now[`LINK_TX_ERR]; // [R13]
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txcnt_q <= 16'h0000;
    end else if (tx_edge && link_now[`LINK_TX_EN]) begin
      txcnt_q <= txcnt_q + 16'h0001;
    end
  end

  // apb: zero wait, unmapped or read-only writes answer with pslverr
  assign pready = 1'b1;
  always_comb begin
    bus_ok = 1'b0;
    rd_word = 32'h0000_0000;
    case (paddr)
      `REG_STATUS: begin
        bus_ok = !pwrite;
        rd_word = {21'h000000, cfg_done, mode_q == strap_cfg_pkg::mode_mac, cfg_q};
      end
      `REG_CTRL: begin
        bus_ok = 1'b1;
        rd_word = {30'h00000000, ctrl_q};
      end
      `REG_TXCNT: begin
        bus_ok = !pwrite;
        rd_word = {16'h0000, txcnt_q};
      end
      default: begin
        bus_ok = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !bus_ok;
  // read data taken in the setup phase so it stands through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_word;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CTRL_RESET;
    end else if (psel && penable && pwrite && paddr == `REG_CTRL) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_strap_fc_sense: assert property ($rose(cfg_done) |-> // [R01]
    cfg_q[`STRAP_P5_FC] == !$past(strap_now[`STRAP_P5_FC]))
    else $error("flow control strap sense wrong");
  chk_strap_bp_sense: assert property ($rose(cfg_done) |-> // [R02]
    cfg_q[`STRAP_P5_BP] == $past(strap_now[`STRAP_P5_BP]))
    else $error("back pressure strap sense wrong");
  chk_strap_coldrop_sense: assert property ($rose(cfg_done) |-> // [R03]
    cfg_q[`STRAP_P5_COLDROP] == !$past(strap_now[`STRAP_P5_COLDROP]))
    else $error("collision drop strap sense wrong");
  chk_strap_size_sense: assert property ($rose(cfg_done) |-> // [R05]
    cfg_q[`STRAP_P5_SIZE] == $past(strap_now[`STRAP_P5_SIZE]))
    else $error("frame size strap sense wrong");
  chk_strap_duplex_sense: assert property ($rose(cfg_done) |-> // [R09]
    cfg_q[`STRAP_SW_DUPLEX] == $past(strap_now[`STRAP_SW_DUPLEX]))
    else $error("switch duplex strap sense wrong");
  chk_strap_backoff_sense: assert property ($rose(cfg_done) |-> // [R04]
    cfg_q[`STRAP_P5_BACKOFF] == $past(strap_now[`STRAP_P5_BACKOFF]))
    else $error("back-off strap sense wrong");
  chk_strap_p4duplex_sense: assert property ($rose(cfg_done) |-> // [R06]
    cfg_q[`STRAP_P5_DUPLEX] == $past(strap_now[`STRAP_P5_DUPLEX]))
    else $error("port four duplex strap sense wrong");
  chk_strap_forcefc_sense: assert property ($rose(cfg_done) |-> // [R07]
    cfg_q[`STRAP_P5_FORCEFC] == $past(strap_now[`STRAP_P5_FORCEFC]))
    else $error("forced flow control strap sense wrong");
  chk_cfg_held_stable: assert property (cfg_done |=> $stable(cfg_q) && cfg_done) // [R15]
    else $error("captured settings changed after capture");
  chk_pins_input_early: assert property (!cfg_done |-> pins_oe_n && clk_oe_n) // [R14]
    else $error("strap pin driven before capture");
  chk_pins_drive_after: assert property (cfg_done && ctrl_q[`CTRL_DRIVE_BIT] |-> // [R14]
    !p5_rx_bit3_strap_fc_oe_n && !sw_rx_bit2_strap_duplex_oe_n)
    else $error("strap pin not driven after capture");
  chk_sw_clk_dir: assert property (cfg_done |-> // [R10] [R11]
    sw_tx_clock_oe_n == (mode_q == strap_cfg_pkg::mode_mac) && sw_rx_clock_oe_n == sw_tx_clock_oe_n)
    else $error("switch clock direction wrong for mode");
  chk_p5_clock_runs: assert property (p5_rx_clock |-> ##[1:clk_half_cyc] !p5_rx_clock) // [R12]
    else $error("port five clock stuck high");
  chk_tx_capture: assert property (tx_edge |=> sw_tx_stb && // [R13]
    sw_tx_nib_q == $past(link_now[`LINK_TX_D0 +: 4]))
    else $error("transmit nibble not captured");

  cov_mac_mode: cover property ($rose(cfg_done) && mode_q == strap_cfg_pkg::mode_mac);
  cov_phy_mode: cover property ($rose(cfg_done) && mode_q == strap_cfg_pkg::mode_phy);
  cov_tx_nibble: cover property (sw_tx_stb && sw_tx_en_q);
  cov_pins_held: cover property (cfg_done && pins_oe_n);
endmodule : strap_cfg

// ==== strap_cfg_defs.svh ====
/*
  constants for the strap capture block: strap bit positions, link
  input positions, register offsets, field positions, reset values, timing.
  assumes it is included by its bare name and never has processes in it.
*/
// Summary of operation
// R01: low fc strap enables port five flow control
// R02: high bp strap enables half-duplex back pressure
// R03: low strap drops excessive collision packets
// R04: high strap enables aggressive back-off
// R05: low strap 1522/1518 limit, high allows 1536
// R06: carrier strap forces port four duplex
// R07: collision strap high forces port four flow control
// R08: high strap enables switch mii flow control
// R09: low strap full duplex, high half duplex
// R10: switch tx clock input mac, output phy
// R11: switch rx clock input mac, output phy
// R12: port five rx clock always driven out
// R13: partner drives switch tx enable, data, error
// R14: strap pins input in reset, output after
// R15: straps latched at release, held until reset
// R16: switch clocks tristated until mode known
`ifndef STRAP_CFG_DEFS_SVH
`define STRAP_CFG_DEFS_SVH

// strap vector positions
`define STRAP_P5_FC 0
`define STRAP_P5_BP 1
`define STRAP_P5_COLDROP 2
`define STRAP_P5_BACKOFF 3
`define STRAP_P5_SIZE 4
`define STRAP_P5_DUPLEX 5
`define STRAP_P5_FORCEFC 6
`define STRAP_SW_FC 7
`define STRAP_SW_DUPLEX 8
`define STRAP_MAC_MODE 9
`define STRAP_W 10
`define CFG_W 9

// link input positions
`define LINK_TX_CLK 0
`define LINK_RX_CLK 1
`define LINK_TX_EN 2
`define LINK_TX_D0 3
`define LINK_TX_ERR 7
`define LINK_W 8

// registers, byte addresses
`define REG_STATUS 12'h000
`define REG_CTRL 12'h004
`define REG_TXCNT 12'h008
`define STATUS_MODE_BIT 9
`define STATUS_DONE_BIT 10
`define CTRL_DRIVE_BIT 0
`define CTRL_CAPTURE_BIT 1
`define CTRL_RESET 2'h3
`define CFG_RESET 9'h005

// mii clock made from pclk: 100 MHz / 4 = 25 MHz
`define MII_CLK_HALF_NS 20
`define PCLK_NS 10
`define MII_CLK_HALF_CYC (`MII_CLK_HALF_NS / `PCLK_NS)

`endif

// ==== strap_cfg_pkg.sv ====
/*
  types for the strap capture block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package strap_cfg_pkg;
  typedef enum logic {mode_phy, mode_mac} mii_mode_e;
  typedef enum logic {cfg_sample, cfg_run} cfg_state_e;
endpackage : strap_cfg_pkg

// ==== sync_if.sv ====
/*
  carrier between the main block and its pin synchroniser: raw pins in,
  synchronised levels and edge pulses out.
  assumes both ends run on pclk.
*/
`timescale 1ns/1ns
interface sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] level;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport sync_side (input raw, output level, output rise, output fall);
  modport user_side (output raw, input level, input rise, input fall);
endinterface : sync_if

// ==== pin_sync.sv ====
/*
  two flip-flop synchroniser with edge detect, W bits wide.
  assumes pclk runs during reset; the chain has no reset so that strap
  levels are already settled when reset is released.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic pclk,
  // pins and results
  sync_if.sync_side s
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // meta_q feeds only sync_q
  always_ff @(posedge pclk) begin
    meta_q <= s.raw;
    sync_q <= meta_q;
    last_q <= sync_q;
  end

  assign s.level = sync_q;
  assign s.rise = sync_q & ~last_q;
  assign s.fall = ~sync_q & last_q;
endmodule : pin_sync

// ==== mii_far_end.sv ====
/*
  far end of the switch mii: a mac or phy that owns both link clocks in mac
  mode and presents random transmit nibbles.
  assumes the bench seeds $urandom and raises run only within frames.
*/
`timescale 1ns/1ns
module mii_far_end (
  // bench control
  input wire logic run,
  input wire logic mac_mode,
  // link pins driven by the far end
  output logic tx_clock,
  output logic rx_clock,
  output logic tx_enable,
  output logic [3:0] tx_data,
  output logic tx_error,
  // nibble shown at the last rising tx clock, {enable, data, error}
  output logic [5:0] sent
);
  initial begin
    tx_clock = 1'b0;
    {tx_enable, tx_data, tx_error} = 6'h00;
    sent = 6'h00;
    // 125 ns link clock, phase kept off the pclk edges; low between frames
    #2;
    forever begin
      #62;
      tx_clock = (run && mac_mode) ? ~tx_clock : 1'b0;
      #63;
      tx_clock = (run && mac_mode) ? ~tx_clock : 1'b0;
    end
  end
  assign rx_clock = tx_clock;
  // new nibble on the falling edge so it is steady at the rising one
  always @(negedge tx_clock) begin
    {tx_enable, tx_data, tx_error} = 6'($urandom);
  end
  always @(posedge tx_clock) begin
    sent = {tx_enable, tx_data, tx_error};
  end
endmodule : mii_far_end

// ==== test_strap_cfg.sv ====
/*
  self-checking bench for the strap capture block: strap levels, pin
  direction, receive pins, transmit nibbles and the apb window.
  assumes the far end model and a 100 MHz pclk; pins are resolved here.
*/
`timescale 1ns/1ns
module test_strap_cfg;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tco, tcoe, rco, rcoe, p5c, stb, en_q, err_q, done, tc, rc, ten, terr;
  logic mac = 1'b0;
  logic run = 1'b0;
  // pin order: p5 valid, p5 bits 3..0, err, crs, col, sw valid, sw bits 3..2
  logic [10:0] st = 11'h000;
  logic [10:0] rxv = 11'h000;
  logic [10:0] po, poe, pl;
  logic [3:0] nib_q, td;
  logic [8:0] cfg;
  logic [5:0] sent;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int ntx = 0;

  always #5 pclk = ~pclk;
  // a released strap pin sits at its pull level
  assign pl = (poe & st) | (~poe & po);

  strap_cfg i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw_mac_mode(mac), .p5_rx_clock(p5c),
    .p5_rx_valid_i(pl[10]), .p5_rx_valid_o(po[10]), .p5_rx_valid_oe_n(poe[10]),
    .p5_rx_bit3_strap_fc_i(pl[9]), .p5_rx_bit3_strap_fc_o(po[9]),
    .p5_rx_bit3_strap_fc_oe_n(poe[9]), .p5_rx_bit2_strap_bp_i(pl[8]),
    .p5_rx_bit2_strap_bp_o(po[8]), .p5_rx_bit2_strap_bp_oe_n(poe[8]),
    .p5_rx_bit1_strap_coldrop_i(pl[7]), .p5_rx_bit1_strap_coldrop_o(po[7]),
    .p5_rx_bit1_strap_coldrop_oe_n(poe[7]), .p5_rx_bit0_strap_backoff_i(pl[6]),
    .p5_rx_bit0_strap_backoff_o(po[6]), .p5_rx_bit0_strap_backoff_oe_n(poe[6]),
    .p5_rx_error_strap_size_i(pl[5]), .p5_rx_error_strap_size_o(po[5]),
    .p5_rx_error_strap_size_oe_n(poe[5]), .p5_carrier_strap_duplex_i(pl[4]),
    .p5_carrier_strap_duplex_o(po[4]), .p5_carrier_strap_duplex_oe_n(poe[4]),
    .p5_collision_strap_forcefc_i(pl[3]), .p5_collision_strap_forcefc_o(po[3]),
    .p5_collision_strap_forcefc_oe_n(poe[3]),
    .sw_tx_clock_i(tcoe ? tc : tco), .sw_tx_clock_o(tco), .sw_tx_clock_oe_n(tcoe),
    .sw_rx_clock_i(rcoe ? rc : rco), .sw_rx_clock_o(rco), .sw_rx_clock_oe_n(rcoe),
    .sw_tx_enable(ten), .sw_tx_bit3(td[3]), .sw_tx_bit2(td[2]), .sw_tx_bit1(td[1]),
    .sw_tx_bit0(td[0]), .sw_tx_error(terr),
    .sw_rx_valid_i(pl[2]), .sw_rx_valid_o(po[2]), .sw_rx_valid_oe_n(poe[2]),
    .sw_rx_bit3_strap_fc_i(pl[1]), .sw_rx_bit3_strap_fc_o(po[1]),
    .sw_rx_bit3_strap_fc_oe_n(poe[1]), .sw_rx_bit2_strap_duplex_i(pl[0]),
    .sw_rx_bit2_strap_duplex_o(po[0]), .sw_rx_bit2_strap_duplex_oe_n(poe[0]),
    .p5_rx_valid_in(rxv[10]), .p5_rx_data_in(rxv[9:6]), .p5_rx_err_in(rxv[5]),
    .p5_crs_in(rxv[4]), .p5_col_in(rxv[3]), .sw_rx_valid_in(rxv[2]),
    .sw_rx_data_in(rxv[1:0]), .sw_tx_stb(stb), .sw_tx_en_q(en_q), .sw_tx_nib_q(nib_q),
    .sw_tx_err_q(err_q), .cfg_q(cfg), .cfg_done(done));

  mii_far_end i_far (.run(run), .mac_mode(mac), .tx_clock(tc), .rx_clock(rc),
    .tx_enable(ten), .tx_data(td), .tx_error(terr), .sent(sent));

  function automatic logic [8:0] exp_cfg(input logic [10:0] s);
    return {s[0], s[1], s[3], s[4], s[5], s[6], ~s[7], s[8], ~s[9]};
  endfunction : exp_cfg

  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic do_reset(input logic [10:0] s, input logic m);
    presetn <= 1'b0;
    st <= s;
    mac <= m;
    run <= 1'b0;
    repeat (5) @(posedge pclk);
    check(poe, 11'h7ff);
    check({tcoe, rcoe, done}, 3'b110);
    ntx = 0;
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset

  // the nibble seen must be the one the far end showed at its clock rise
  always @(posedge pclk) begin
    if (stb === 1'b1 && mac === 1'b1) begin
      check({en_q, nib_q, err_q}, sent);
      ntx += sent[5];
    end
  end

  // hang guard: the whole run needs a few thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    logic [31:0] r;
    logic e, prev;
    logic [10:0] s;
    int n;
    void'($urandom(32'hb31e));
    for (int i = 0; i < 6; i++) begin
      // corners first: all pulled down, then all pulled up
      s = (i == 0) ? 11'h000 : (i == 1) ? 11'h3fb : 11'($urandom) & 11'h3fb;
      do_reset(s, i[0]);
      check(cfg, exp_cfg(s));
      check({done, poe}, 12'h800);
      check({tcoe, rcoe}, {2{i[0]}});
      n = 0;
      prev = p5c;
      repeat (40) begin
        @(posedge pclk);
        n += int'(p5c & ~prev);
        prev = p5c;
        if (!i[0]) check({tco, rco}, {p5c, p5c});
      end
      check(n, 10);
      run <= 1'b1;
      repeat (3) begin
        rxv <= 11'($urandom);
        repeat (30) @(posedge pclk);
        check({po, pl}, {rxv, rxv});
      end
      repeat (300) @(posedge pclk);
      run <= 1'b0;
      repeat (20) @(posedge pclk);
      apb(1'b0, 12'h008, 32'h0, r, e);
      if (i[0]) check({e, r}, {17'h0, 16'(ntx)});
      // release the pins, move the straps: captured settings must not follow
      apb(1'b1, 12'h004, 32'h0, r, e);
      st <= ~s & 11'h3fb;
      repeat (3) @(posedge pclk);
      check(poe, 11'h7ff);
      apb(1'b1, 12'h000, 32'hffffffff, r, e);
      check(e, 1'b1);
      apb(1'b0, 12'h000, 32'h0, r, e);
      check({e, r}, {22'h1, i[0], exp_cfg(s)});
      apb(1'b0, 12'h00c, 32'h0, r, e);
      check({e, r}, {1'b1, 32'h0});
      apb(1'b1, 12'h004, 32'h3, r, e);
      apb(1'b0, 12'h004, 32'h0, r, e);
      check({e, r}, 33'h3);
    end
    conclude();
  end
endmodule : test_strap_cfg
